// ### include/nvr_cfg.svh
// Offsets, bit positions, address ranges and timing of the NVM access block
`ifndef NVR_CFG_SVH
`define NVR_CFG_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define NVR_OFS_DATA_LO 3'h0
`define NVR_OFS_DATA_HI 3'h1
`define NVR_OFS_ADDR_LO 3'h2
`define NVR_OFS_ADDR_HI 3'h3
`define NVR_OFS_CTRL 3'h4
`define NVR_OFS_KEY 3'h5
// ****************************************************************
// Control register bits
// ****************************************************************
`define NVR_BIT_REGION 6
`define NVR_BIT_LATCH 5
`define NVR_BIT_ERASE 4
`define NVR_BIT_ERR 3
`define NVR_BIT_ALLOW 2
`define NVR_BIT_GO 1
`define NVR_BIT_RD 0
// ****************************************************************
// Values
// ****************************************************************
`define NVR_KEY_FIRST 8'h55
`define NVR_KEY_SECOND 8'haa
`define NVR_BLANK_WORD 14'h3fff
`define NVR_ADDR_HI_FILL 1'b1
`define NVR_UID_LO 16'h8000
`define NVR_UID_HI 16'h8003
`define NVR_DEV_LO 16'h8005
`define NVR_DEV_HI 16'h8006
`define NVR_CFG_LO 16'h8007
`define NVR_CFG_HI 16'h800b
`define NVR_EE_LO 16'hf000
`define NVR_EE_HI 16'hf0ff
// ****************************************************************
// Timing
// ****************************************************************
`define NVR_CLK_PERIOD_NS 50
`define NVR_ERASE_TIME_NS 2000
`define NVR_PROG_TIME_NS 2000
`endif

// ### include/nvr_pkg.sv
// Types shared by the NVM access block
package nvr_pkg;
  typedef enum logic [2:0] {
    NVR_ST_IDLE = 3'b000,
    NVR_ST_RD1 = 3'b001,
    NVR_ST_RD2 = 3'b010,
    NVR_ST_PROG = 3'b011,
    NVR_ST_WAIT = 3'b100
  } nvr_state_t;
  typedef enum logic [1:0] {
    NVR_KEY_IDLE = 2'b00,
    NVR_KEY_GOT1 = 2'b01,
    NVR_KEY_GOT2 = 2'b10
  } nvr_key_t;
endpackage

// ### hw/nvr_unlock.sv
// Unlock key sequence tracker
`timescale 1ns/1ns
`include "nvr_cfg.svh"
module nvr_unlock import nvr_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic go_wr,
  input wire logic other_wr,
  output logic unlocked,
  output logic broken
);
  nvr_key_t st;
  nvr_key_t next_st;

  always_comb begin
    next_st = st;
    broken = 1'b0;
    case (st)
      NVR_KEY_IDLE: begin
        if (key_wr && key_data == `NVR_KEY_FIRST) begin
          next_st = NVR_KEY_GOT1;
        end
      end
      NVR_KEY_GOT1: begin
        if (key_wr && key_data == `NVR_KEY_SECOND) begin
          next_st = NVR_KEY_GOT2;
        end else if (key_wr || go_wr || other_wr) begin
          broken = 1'b1;
          next_st = NVR_KEY_IDLE;
        end
      end
      NVR_KEY_GOT2: begin
        // Only the very next write may be the go write
        if (go_wr) begin
          next_st = NVR_KEY_IDLE;
        end else if (key_wr || other_wr) begin
          broken = 1'b1;
          next_st = NVR_KEY_IDLE;
        end
      end
      default: begin
        next_st = NVR_KEY_IDLE;
      end
    endcase
  end

  assign unlocked = (st == NVR_KEY_GOT2);

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= NVR_KEY_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule // nvr_unlock

// ### hw/nvr_access.sv
// NVM region select, read path and erase/latch/program command engine
//
// Contract
// - Region select high steers reads and writes to the secondary region.
// - Secondary read outside mapped ranges clears data pair to zero.
// - User ID words 8000h-8003h are readable and writable.
// - Device and revision words 8005h-8006h read only, writes rejected.
// - Configuration words 8007h-800Bh read only.
// - Data EEPROM at F000h-F0FFh readable and writable.
// - Go with address on protected location sets write error flag.
// - Any reset during a self-write sets the write error flag.
// - Broken unlock sequence sets error flag and starts nothing.
// - Software may set the error flag; only software clears it.
// - Erase mode with region select low erases the addressed 32-word row; protected row gives error.
// - Latch-only mode with region select low copies data pair into selected latch, no memory access.
// - Program mode writes latched row to flash; protected row gives error.
// - Latches return to blank after a program operation.
// - Go is accepted only right after key writes 55h then AAh.
// - Operations self-timed; hardware clears go; software clear ignored.
// - Program allow low blocks all erase and program cycles.
// - Read start loads data pair, then clears itself; software only sets.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "nvr_cfg.svh"
module nvr_access import nvr_pkg::*; #(
  parameter int ROW_WORDS = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic write_protect,
  output logic mem_secondary,
  output logic [14:0] mem_addr,
  output logic mem_rd_en,
  input wire logic [13:0] mem_rdata,
  output logic mem_wr_en,
  output logic [13:0] mem_wr_data,
  output logic mem_erase_en,
  output logic busy
);
  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam int IDX_W = $clog2(ROW_WORDS);
  localparam int TMR_W = 16;
  localparam int ERASE_CYC = (`NVR_ERASE_TIME_NS + `NVR_CLK_PERIOD_NS - 1) / `NVR_CLK_PERIOD_NS;
  localparam int PROG_CYC = (`NVR_PROG_TIME_NS + `NVR_CLK_PERIOD_NS - 1) / `NVR_CLK_PERIOD_NS;

  initial begin
    if (ROW_WORDS < 2 || ROW_WORDS > 256 || (1 << IDX_W) != ROW_WORDS) begin
      $error("ROW_WORDS must be a power of two from 2 to 256");
    end
    if (ERASE_CYC >= (1 << TMR_W) || PROG_CYC >= (1 << TMR_W)) begin
      $error("Operation time does not fit the timer");
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] data_lo, next_data_lo;
  logic [5:0] data_hi, next_data_hi;
  logic [7:0] adr_lo, next_adr_lo;
  logic [6:0] adr_hi, next_adr_hi;
  logic region, next_region;
  logic latch_only, next_latch_only;
  logic erase_en, next_erase_en;
  logic err, next_err;
  logic allow, next_allow;
  logic go, next_go;
  logic rd_start, next_rd_start;
  logic [7:0] next_reg_rdata;
  nvr_state_t state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [IDX_W-1:0] idx, next_idx;
  logic [13:0] latch [ROW_WORDS];
  logic [13:0] next_latch [ROW_WORDS];
  logic next_mem_secondary;
  logic [14:0] next_mem_addr;
  logic next_mem_rd_en;
  logic next_mem_wr_en;
  logic [13:0] next_mem_wr_data;
  logic next_mem_erase_en;
  logic wp_meta, wp_sync;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [14:0] addr15;
  logic [15:0] full_addr;
  logic [13:0] data_word;
  logic in_uid, in_dev, in_cfg, in_ee;
  logic rd_ok, sec_wr_ok, wr_busy;
  logic key_wr, go_wr, other_wr, ctrl_wr;
  logic unlocked, key_broken;
  logic start_req, start_err, start_ok, latch_load, eng_done;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  assign addr15 = {adr_hi, adr_lo};
  assign full_addr = {region, addr15};
  assign data_word = {data_hi, data_lo};
  assign in_uid = in_rng(full_addr, `NVR_UID_LO, `NVR_UID_HI);
  assign in_dev = in_rng(full_addr, `NVR_DEV_LO, `NVR_DEV_HI);
  assign in_cfg = in_rng(full_addr, `NVR_CFG_LO, `NVR_CFG_HI);
  assign in_ee = in_rng(full_addr, `NVR_EE_LO, `NVR_EE_HI);
  assign rd_ok = !region || in_uid || in_dev || in_cfg || in_ee;
  assign sec_wr_ok = in_uid || in_ee;
  assign wr_busy = (state == NVR_ST_PROG) || (state == NVR_ST_WAIT);
  assign busy = (state != NVR_ST_IDLE);

  assign ctrl_wr = reg_wr && (reg_addr == `NVR_OFS_CTRL);
  assign key_wr = reg_wr && (reg_addr == `NVR_OFS_KEY);
  assign go_wr = ctrl_wr && reg_wdata[`NVR_BIT_GO];
  assign other_wr = reg_wr && !key_wr && !go_wr;

  nvr_unlock u_unlock (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .key_wr(key_wr),
    .key_data(reg_wdata),
    .go_wr(go_wr),
    .other_wr(other_wr),
    .unlocked(unlocked),
    .broken(key_broken)
  );

  // Software clearing go mid-operation is ignored since only a set is decoded
  assign start_req = go_wr && unlocked && allow && !go && (state == NVR_ST_IDLE);
  assign latch_load = !region && !erase_en && latch_only;
  // Latch loads skip protection
  assign start_err = start_req && (region ? !sec_wr_ok : (!latch_load && wp_sync));
  assign start_ok = start_req && !start_err;
  assign eng_done = (state == NVR_ST_WAIT) && (tmr == '0);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else if (ce) begin
      wp_meta <= write_protect;
      wp_sync <= wp_meta;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb begin
    next_data_lo = data_lo;
    next_data_hi = data_hi;
    next_adr_lo = adr_lo;
    next_adr_hi = adr_hi;
    next_region = region;
    next_latch_only = latch_only;
    next_erase_en = erase_en;
    next_err = err;
    next_allow = allow;
    next_go = go;
    next_rd_start = rd_start;
    next_reg_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `NVR_OFS_DATA_LO: next_data_lo = reg_wdata;
        `NVR_OFS_DATA_HI: next_data_hi = reg_wdata[5:0];
        `NVR_OFS_ADDR_LO: next_adr_lo = reg_wdata;
        `NVR_OFS_ADDR_HI: next_adr_hi = reg_wdata[6:0];
        `NVR_OFS_CTRL: begin
          next_region = reg_wdata[`NVR_BIT_REGION];
          next_latch_only = reg_wdata[`NVR_BIT_LATCH];
          next_erase_en = reg_wdata[`NVR_BIT_ERASE];
          next_allow = reg_wdata[`NVR_BIT_ALLOW];
          next_err = reg_wdata[`NVR_BIT_ERR];
        end
        default: begin
        end
      endcase
    end
    if (state == NVR_ST_RD2) begin
      next_rd_start = 1'b0;
      if (rd_ok) begin
        next_data_lo = mem_rdata[7:0];
        // EEPROM words are one byte wide
        next_data_hi = in_ee ? 6'h00 : mem_rdata[13:8];
      end else begin
        next_data_lo = 8'h00;
        next_data_hi = 6'h00;
      end
    end
    if (ctrl_wr && reg_wdata[`NVR_BIT_RD]) begin
      next_rd_start = 1'b1;
    end
    if (start_ok && !latch_load) begin
      next_go = 1'b1;
    end
    if (eng_done) begin
      next_go = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (start_err || key_broken) begin
      next_err = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `NVR_OFS_DATA_LO: next_reg_rdata = data_lo;
        `NVR_OFS_DATA_HI: next_reg_rdata = {2'b00, data_hi};
        `NVR_OFS_ADDR_LO: next_reg_rdata = adr_lo;
        `NVR_OFS_ADDR_HI: next_reg_rdata = {`NVR_ADDR_HI_FILL, adr_hi};
        `NVR_OFS_CTRL: next_reg_rdata = {1'b0, region, latch_only, erase_en, err, allow, go, rd_start};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_lo <= 8'h00;
      data_hi <= 6'h00;
      adr_lo <= 8'h00;
      adr_hi <= 7'h00;
      region <= 1'b0;
      latch_only <= 1'b0;
      erase_en <= 1'b0;
      // A reset that cuts a self-write leaves the flag set
      err <= err | wr_busy;
      allow <= 1'b0;
      go <= 1'b0;
      rd_start <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      data_lo <= next_data_lo;
      data_hi <= next_data_hi;
      adr_lo <= next_adr_lo;
      adr_hi <= next_adr_hi;
      region <= next_region;
      latch_only <= next_latch_only;
      erase_en <= next_erase_en;
      err <= next_err;
      allow <= next_allow;
      go <= next_go;
      rd_start <= next_rd_start;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************************************
  // Command engine
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_idx = idx;
    next_latch = latch;
    next_mem_secondary = mem_secondary;
    next_mem_addr = mem_addr;
    next_mem_wr_data = mem_wr_data;
    next_mem_rd_en = 1'b0;
    next_mem_wr_en = 1'b0;
    next_mem_erase_en = 1'b0;
    case (state)
      NVR_ST_IDLE: begin
        if (start_ok) begin
          next_mem_secondary = region;
          if (region) begin
            next_mem_addr = addr15;
            next_mem_wr_data = data_word;
            next_mem_wr_en = 1'b1;
            next_tmr = TMR_W'(PROG_CYC - 1);
            next_state = NVR_ST_WAIT;
          end else if (erase_en) begin
            // Whole row, data pair unused
            next_mem_addr = {addr15[14:IDX_W], IDX_W'(0)};
            next_mem_erase_en = 1'b1;
            next_tmr = TMR_W'(ERASE_CYC - 1);
            next_state = NVR_ST_WAIT;
          end else if (latch_only) begin
            next_latch[adr_lo[IDX_W-1:0]] = data_word;
          end else begin
            next_idx = '0;
            next_state = NVR_ST_PROG;
          end
        end else if (rd_start) begin
          next_mem_secondary = region;
          next_mem_addr = addr15;
          next_mem_rd_en = 1'b1;
          next_state = NVR_ST_RD1;
        end
      end
      NVR_ST_RD1: begin
        next_state = NVR_ST_RD2;
      end
      NVR_ST_RD2: begin
        next_state = NVR_ST_IDLE;
      end
      NVR_ST_PROG: begin
        next_mem_addr = {addr15[14:IDX_W], idx};
        next_mem_wr_data = latch[idx];
        next_mem_wr_en = 1'b1;
        next_idx = idx + IDX_W'(1);
        if (idx == IDX_W'(ROW_WORDS - 1)) begin
          next_tmr = TMR_W'(PROG_CYC - 1);
          next_state = NVR_ST_WAIT;
        end
      end
      NVR_ST_WAIT: begin
        if (tmr == '0) begin
          for (int i = 0; i < ROW_WORDS; i++) begin
            next_latch[i] = `NVR_BLANK_WORD;
          end
          next_state = NVR_ST_IDLE;
        end else begin
          next_tmr = tmr - TMR_W'(1);
        end
      end
      default: begin
        next_state = NVR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= NVR_ST_IDLE;
      tmr <= '0;
      idx <= '0;
      for (int i = 0; i < ROW_WORDS; i++) begin
        latch[i] <= `NVR_BLANK_WORD;
      end
      mem_secondary <= 1'b0;
      mem_addr <= 15'h0000;
      mem_wr_data <= 14'h0000;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_erase_en <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      tmr <= next_tmr;
      idx <= next_idx;
      latch <= next_latch;
      mem_secondary <= next_mem_secondary;
      mem_addr <= next_mem_addr;
      mem_wr_data <= next_mem_wr_data;
      mem_rd_en <= next_mem_rd_en;
      mem_wr_en <= next_mem_wr_en;
      mem_erase_en <= next_mem_erase_en;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_erase_go;
    ce && start_ok && !region && erase_en;
  endsequence
  sequence s_erase_out;
    mem_erase_en && (state == NVR_ST_WAIT) && (mem_addr[IDX_W-1:0] == '0);
  endsequence

  chk_erase_row: assert property (s_erase_go |=> s_erase_out)
    else $error("Erase did not start on the row base");
  chk_prog_start: assert property ((ce && start_ok && !region && !erase_en && !latch_only)
    |=> (state == NVR_ST_PROG) && go && (idx == '0))
    else $error("Program did not enter the row walk");
  chk_latch_load: assert property ((ce && start_ok && latch_load)
    |=> latch[$past(adr_lo[IDX_W-1:0])] == $past(data_word) && !go && !mem_wr_en)
    else $error("Latch load wrong or touched memory");
  chk_latch_blank: assert property ((ce && eng_done) |=> latch[0] == `NVR_BLANK_WORD && !go)
    else $error("Latches not blank or go not cleared at completion");
  chk_go_key: assert property ($rose(go) |-> $past(unlocked) && $past(allow))
    else $error("Go set without key sequence or allow");
  chk_protect_err: assert property ((ce && start_err) |=> err && !go && (state == NVR_ST_IDLE))
    else $error("Protected write not refused with error");
  chk_broken_err: assert property ((ce && key_broken) |=> err && !go)
    else $error("Broken key sequence did not flag error");
  chk_err_sticky: assert property ($fell(err) |-> $past(ctrl_wr) && !$past(reg_wdata[`NVR_BIT_ERR]))
    else $error("Error flag cleared without software");
  chk_read_done: assert property ((ce && state == NVR_ST_RD2 && !rd_ok)
    |=> data_lo == 8'h00 && data_hi == 6'h00 && !rd_start)
    else $error("Unmapped read did not clear data pair");
  chk_read_time: assert property ((ce && mem_rd_en) |=> (state == NVR_ST_RD2))
    else $error("Read capture not one cycle after request");
endmodule // nvr_access

// ### testbench/tb_top.sv
// Self-checking testbench for the NVM region access and write control block
`timescale 1ns/1ns
`include "nvr_cfg.svh"
module tb_top;
  // ****************************************************************
  // Constants and signals
  // ****************************************************************
  localparam logic [2:0] A_DL = `NVR_OFS_DATA_LO;
  localparam logic [2:0] A_DH = `NVR_OFS_DATA_HI;
  localparam logic [2:0] A_AL = `NVR_OFS_ADDR_LO;
  localparam logic [2:0] A_AH = `NVR_OFS_ADDR_HI;
  localparam logic [2:0] A_C = `NVR_OFS_CTRL;
  localparam logic [2:0] A_K = `NVR_OFS_KEY;
  localparam logic [7:0] RD = 8'h01 << `NVR_BIT_RD;
  localparam logic [7:0] GO = 8'h01 << `NVR_BIT_GO;
  localparam logic [7:0] AL = 8'h01 << `NVR_BIT_ALLOW;
  localparam logic [7:0] ER = 8'h01 << `NVR_BIT_ERR;
  localparam logic [7:0] ES = 8'h01 << `NVR_BIT_ERASE;
  localparam logic [7:0] LT = 8'h01 << `NVR_BIT_LATCH;
  localparam logic [7:0] RG = 8'h01 << `NVR_BIT_REGION;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic write_protect = 1'b0;
  logic mem_secondary;
  logic [14:0] mem_addr;
  logic mem_rd_en;
  logic [13:0] mem_rdata = 14'h0000;
  logic mem_wr_en;
  logic [13:0] mem_wr_data;
  logic mem_erase_en;
  logic busy;
  int failures = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  int er_cnt = 0;
  logic [13:0] wr_seen [0:31];
  logic [14:0] er_addr;
  logic wr_sec;
  logic rd_sec;

  always #25 clk = ~clk;

  nvr_access dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_protect(write_protect),
    .mem_secondary(mem_secondary), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .mem_erase_en(mem_erase_en), .busy(busy));

  // ****************************************************************
  // Memory array stand-in
  // ****************************************************************
  // Between reads the data bus toggles so a stale word is never mistaken for a fresh one
  always @(posedge clk) begin
    mem_rdata <= mem_rd_en ? (mem_addr[13:0] ^ 14'h1555) : ~mem_rdata;
    if (mem_rd_en) rd_sec <= mem_secondary;
    if (mem_wr_en) begin
      wr_cnt <= wr_cnt + 1;
      wr_seen[mem_addr[4:0]] <= mem_wr_data;
      wr_sec <= mem_secondary;
    end
    if (mem_erase_en) begin
      er_cnt <= er_cnt + 1;
      er_addr <= mem_addr;
    end
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] e, input string m);
    logic [7:0] d;
    rd(A_C, d);
    chk(16'(d), 16'(e), m);
  endtask

  task automatic set_addr(input logic [15:0] a);
    wr(A_AL, a[7:0]);
    wr(A_AH, a[15:8]);
  endtask

  task automatic set_data(input logic [13:0] d);
    wr(A_DL, d[7:0]);
    wr(A_DH, {2'b00, d[13:8]});
  endtask

  // Mode is taken from the control value before the go write, so it is set first
  task automatic go(input logic [7:0] c);
    wr(A_C, c);
    wr(A_K, `NVR_KEY_FIRST);
    wr(A_K, `NVR_KEY_SECOND);
    wr(A_C, c | GO);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(16'(busy), 16'h0000, "engine idle");
  endtask

  function automatic logic is_ee(input logic [15:0] a);
    return a >= `NVR_EE_LO && a <= `NVR_EE_HI;
  endfunction

  function automatic logic can_wr(input logic [15:0] a);
    return (a >= `NVR_UID_LO && a <= `NVR_UID_HI) || is_ee(a);
  endfunction

  function automatic logic can_rd(input logic [15:0] a);
    return can_wr(a) || (a >= `NVR_DEV_LO && a <= `NVR_CFG_HI);
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    wr(A_C, 8'h00);
    rc(8'h00, "error flag cleared by software");
    wr(A_C, ER);
    rc(ER, "error flag set by software");
    wr(A_C, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_read;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [13:0] e;
    e = 14'h1234 ^ 14'h1555;
    set_addr(16'h1234);
    wr(A_C, RD);
    wait_idle;
    rc(8'h00, "read start self clears");
    rd(A_DL, lo);
    rd(A_DH, hi);
    chk({hi, lo}, {2'b00, e}, "code flash word");
    chk(16'(rd_sec), 16'h0000, "code flash region");
    $display("test read done");
  endtask

  task automatic t_sec;
    logic [15:0] a [9] = '{16'h8000, 16'h8003, 16'h8004, 16'h8005, 16'h800b, 16'h800c, 16'hf000,
      16'hf0ff, 16'hf100};
    logic [7:0] lo;
    logic [7:0] hi;
    logic [13:0] e;
    for (int i = 0; i < 9; i++) begin
      set_data(14'h3fff);
      set_addr(a[i]);
      wr(A_C, RG | RD);
      wait_idle;
      rd(A_DL, lo);
      rd(A_DH, hi);
      e = can_rd(a[i]) ? (a[i][13:0] ^ 14'h1555) : 14'h0000;
      if (is_ee(a[i])) e[13:8] = 6'h00;
      chk({hi, lo}, {2'b00, e}, "secondary read");
      if (can_rd(a[i])) chk(16'(rd_sec), 16'h0001, "secondary region");
    end
    $display("test secondary read done");
  endtask

  task automatic t_prog;
    @(posedge clk);
    write_protect <= 1'b1;
    wr_cnt = 0;
    er_cnt = 0;
    set_addr(16'h0440);
    set_data(14'h1a2b);
    go(AL | LT);
    set_addr(16'h045f);
    set_data(14'h0c3d);
    go(AL | LT);
    repeat (3) @(posedge clk);
    chk(16'(wr_cnt + er_cnt), 16'h0000, "latch load touched memory");
    rc(AL | LT, "latch load error or go");
    @(posedge clk);
    write_protect <= 1'b0;
    set_addr(16'h0440);
    go(AL);
    rc(AL | GO, "go during program");
    wr(A_C, AL);
    rc(AL | GO, "software clear of go");
    wait_idle;
    rc(AL, "control after program");
    chk(16'(wr_cnt), 16'h0020, "row word count");
    chk(16'(wr_seen[0]), 16'h1a2b, "first latch");
    chk(16'(wr_seen[31]), 16'h0c3d, "last latch");
    chk(16'(wr_seen[7]), 16'h3fff, "unloaded latch");
    go(AL);
    wait_idle;
    for (int i = 0; i < 32; i++) chk(16'(wr_seen[i]), 16'h3fff, "latch blank after program");
    $display("test program done");
  endtask

  task automatic t_erase;
    wr_cnt = 0;
    er_cnt = 0;
    set_addr(16'h0453);
    go(AL | ES);
    wait_idle;
    chk(16'(er_cnt), 16'h0001, "erase pulses");
    chk(16'(er_addr), 16'h0440, "erase row base");
    chk(16'(wr_cnt), 16'h0000, "erase wrote words");
    rc(AL | ES, "control after erase");
    $display("test erase done");
  endtask

  task automatic t_prot;
    logic [7:0] m [2] = '{ES, 8'h00};
    @(posedge clk);
    write_protect <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr_cnt = 0;
      er_cnt = 0;
      go(AL | m[i]);
      wait_idle;
      rc(AL | m[i] | ER, "protected row");
      chk(16'(wr_cnt + er_cnt), 16'h0000, "protected row touched");
    end
    @(posedge clk);
    write_protect <= 1'b0;
    $display("test protect done");
  endtask

  task automatic t_regw;
    logic [15:0] a [5] = '{16'h8000, 16'h8005, 16'h800b, 16'hf010, 16'h8004};
    for (int i = 0; i < 5; i++) begin
      set_addr(a[i]);
      set_data(14'h0abc);
      wr_cnt = 0;
      go(AL | RG);
      wait_idle;
      if (can_wr(a[i])) begin
        chk(16'(wr_cnt), 16'h0001, "secondary write");
        chk({wr_sec, 1'b0, wr_seen[a[i][4:0]]}, 16'h8abc, "secondary word");
        rc(AL | RG, "secondary write error");
      end else begin
        chk(16'(wr_cnt), 16'h0000, "read only write");
        rc(AL | RG | ER, "read only error");
      end
    end
    $display("test region write done");
  endtask

  task automatic t_unlock;
    wr_cnt = 0;
    er_cnt = 0;
    wr(A_C, AL);
    wr(A_K, `NVR_KEY_FIRST);
    wr(A_DL, 8'h00);
    // Flag is read before the next control write, which clears it again
    rc(AL | ER, "sequence broken by data write");
    wr(A_C, AL | GO);
    wait_idle;
    rc(AL, "go after broken sequence");
    wr(A_K, `NVR_KEY_FIRST);
    wr(A_K, 8'h33);
    rc(AL | ER, "wrong second key");
    wr(A_C, AL | GO);
    wait_idle;
    rc(AL, "go without keys");
    go(8'h00);
    wait_idle;
    rc(8'h00, "go with program disallowed");
    chk(16'(wr_cnt + er_cnt), 16'h0000, "refused go touched memory");
    $display("test unlock done");
  endtask

  task automatic t_rstmid;
    set_addr(16'h0440);
    go(AL);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(ER, "reset during write");
    wr(A_C, 8'h00);
    rc(8'h00, "software clear");
    $display("test reset mid write done");
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_read;
    t_sec;
    t_prog;
    t_erase;
    t_prot;
    t_regw;
    t_unlock;
    t_rstmid;
    stop_test;
  end

  // Whole run needs about 800 cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule // tb_top
